// ---- logic/rsc_reset_ctrl.sv ----
// System reset controller: sequencing, pin shaping, status over AXI4-Lite.
// Assumes slow_tick_i is a one-cycle pulse per slow clock period, and that
// the supply controller and watchdog signals are on clk_i.
//
// How it works
// - Three active-low resets from slow-clock sequencing
// - Power-up drives pin, then no user reset until pin seen high
// - Pin low gives user reset unless disabled
// - Pin level readable, sampled every clock
// - Pin falling edge sets sticky, read clears
// - Interrupt when enable off, irq enable on
// - Pin pulse lasts two power length-plus-one ticks
// - Mode register survives all but general reset
// - Cause updates only at processor reset release
// - Core reset clears mode, reports general
// - Core reset from backup reports backup
// - Resynchronised pin low asserts processor, peripheral
// - User reset ends after five ticks, cause four
// - Pin held low keeps internal resets asserted
// - Command bits reset processor, peripherals, pin
// - Command resets immediate, held three slow ticks
// - Own pin pulse never starts user reset
// - Software cause only with processor command
// - Busy flag blocks further command writes
// - Watchdog three ticks, processor-only option
// - Watchdog ignored when reset not allowed
// - Priority general, backup, watchdog, software, user
// - Cause codes zero to four
// - Writes need key byte a5
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module rsc_reset_ctrl (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic slow_tick_i,
   input wire logic core_rst_i,
   input wire logic from_backup_i,
   input wire logic wdt_fault_i,
   input wire logic watchdog_cpu_only_i,
   input wire logic watchdog_reset_allow_i,
   input wire logic pin_i,
   output logic pin_o,
   output logic pin_oe_o,
   output logic cpu_rstn_o,
   output logic periph_rstn_o,
   output logic irq_o,
   input wire logic [7:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [7:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i
);

   // ************************************************************
   // Declarations
   // ************************************************************
   rsc_pkg::rsc_state_type state_reg;
   rsc_pkg::rsc_mode_type mode_reg;
   logic [2:0] cnt_reg;
   logic [2:0] pending_reg;
   logic [2:0] cause_reg;
   logic busy_reg;
   logic cpu_rstn_reg;
   logic per_rstn_reg;
   logic pin_meta_reg;
   logic pin_sync_reg;
   logic pin_prev_reg;
   logic fall_reg;
   logic irq_reg;
   logic own_drive_reg;
   logic [16:0] pin_cnt_reg;
   logic [16:0] pin_cnt_next;
   logic pin_oe_reg;
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic wr_fire;
   logic key_ok;
   logic cmd_ok;
   logic mode_wr;
   logic sr_read;
   logic wd_hit;
   logic user_hit;
   logic pin_start;
   logic [31:0] rd_word;
   logic rd_hit;

   // ************************************************************
   // Pin synchroniser and status bits
   // ************************************************************
   // two-flop sampling
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_meta_reg <= 1'b1;
         pin_sync_reg <= 1'b1;
         pin_prev_reg <= 1'b1;
      end else begin
         pin_meta_reg <= pin_i;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // sticky fall, set beats read clear
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fall_reg <= 1'b0;
      end else if (pin_prev_reg && !pin_sync_reg) begin
         fall_reg <= 1'b1;
      end else if (sr_read) begin
         fall_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= fall_reg && !sr_read && !mode_reg.en && mode_reg.irq_en;
      end
   end

   // ************************************************************
   // Mode register
   // ************************************************************
   // key check on writes
   assign key_ok = wdata_reg[rsc_pkg::KEY_POS +: 8] == rsc_pkg::KEY_VAL && wstrb_reg[3];
   assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign mode_wr = wr_fire && key_ok && awaddr_reg == rsc_pkg::ADDR_MODE;

   // kept through every reset but a general one
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_reg <= rsc_pkg::MODE_RESET;
      end else if (core_rst_i && !from_backup_i) begin
         mode_reg <= rsc_pkg::MODE_RESET;
      end else if (mode_wr) begin
         mode_reg.en <= wdata_reg[rsc_pkg::MD_EN_BIT];
         mode_reg.irq_en <= wdata_reg[rsc_pkg::MD_IRQ_BIT];
         mode_reg.len <= wdata_reg[rsc_pkg::MD_LEN_POS +: 4];
      end
   end

   // ************************************************************
   // Pin pulse shaping
   // ************************************************************
   // watchdog gated by allow option
   assign wd_hit = wdt_fault_i && watchdog_reset_allow_i && !core_rst_i
      && (state_reg == rsc_pkg::ST_IDLE || state_reg == rsc_pkg::ST_SOFT);
   // busy or reset state refuses commands
   assign cmd_ok = wr_fire && key_ok && awaddr_reg == rsc_pkg::ADDR_CMD && !busy_reg
      && state_reg == rsc_pkg::ST_IDLE && !wd_hit && !core_rst_i;
   assign pin_start = (state_reg == rsc_pkg::ST_GENERAL && !core_rst_i)
      || (cmd_ok && wdata_reg[rsc_pkg::CMD_PIN_BIT])
      || (wd_hit && !watchdog_cpu_only_i);

   // two to the power of length plus one ticks
   always_comb begin
      pin_cnt_next = pin_cnt_reg;
      if (pin_start) begin
         pin_cnt_next = 17'h1 << (5'(mode_reg.len) + 5'h1);
      end else if (slow_tick_i && pin_cnt_reg != 17'h0) begin
         pin_cnt_next = pin_cnt_reg - 17'h1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_cnt_reg <= 17'h0;
         pin_oe_reg <= 1'b0;
      end else begin
         pin_cnt_reg <= pin_cnt_next;
         pin_oe_reg <= pin_cnt_next != 17'h0;
      end
   end

   // own pulse masks user detection until pin seen high
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         own_drive_reg <= 1'b0;
      end else if (pin_start) begin
         own_drive_reg <= 1'b1;
      end else if (pin_cnt_reg == 17'h0 && !pin_oe_reg && pin_sync_reg) begin
         own_drive_reg <= 1'b0;
      end
   end

   // ************************************************************
   // Reset state manager
   // ************************************************************
   // low pin on a slow tick enters user reset
   assign user_hit = state_reg == rsc_pkg::ST_IDLE && slow_tick_i && mode_reg.en
      && !pin_sync_reg && !own_drive_reg && !cmd_ok && !wd_hit;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg <= rsc_pkg::ST_GENERAL;
         cpu_rstn_reg <= 1'b0;
         per_rstn_reg <= 1'b0;
         cnt_reg <= 3'h0;
         pending_reg <= rsc_pkg::CAUSE_GENERAL;
         cause_reg <= rsc_pkg::CAUSE_GENERAL;
         busy_reg <= 1'b0;
      end else if (core_rst_i) begin
         state_reg <= rsc_pkg::ST_GENERAL;
         cpu_rstn_reg <= 1'b0;
         per_rstn_reg <= 1'b0;
         busy_reg <= 1'b0;
         pending_reg <= from_backup_i ? rsc_pkg::CAUSE_BACKUP : rsc_pkg::CAUSE_GENERAL;
      end else if (wd_hit) begin
         state_reg <= rsc_pkg::ST_WDOG;
         cnt_reg <= 3'h0;
         busy_reg <= 1'b0;
         cpu_rstn_reg <= 1'b0;
         per_rstn_reg <= watchdog_cpu_only_i;
         pending_reg <= rsc_pkg::CAUSE_WATCHDOG;
      end else begin
         case (state_reg)
            rsc_pkg::ST_GENERAL: begin
               state_reg <= rsc_pkg::ST_IDLE;
               cpu_rstn_reg <= 1'b1;
               per_rstn_reg <= 1'b1;
               cause_reg <= pending_reg;
            end
            rsc_pkg::ST_IDLE: begin
               if (cmd_ok) begin
                  state_reg <= rsc_pkg::ST_SOFT;
                  cnt_reg <= 3'h0;
                  busy_reg <= 1'b1;
                  cpu_rstn_reg <= !wdata_reg[rsc_pkg::CMD_CPU_BIT];
                  per_rstn_reg <= !wdata_reg[rsc_pkg::CMD_PER_BIT];
                  // software cause only with processor bit
                  if (wdata_reg[rsc_pkg::CMD_CPU_BIT]) begin
                     pending_reg <= rsc_pkg::CAUSE_SOFTWARE;
                  end
               end else if (user_hit) begin
                  state_reg <= rsc_pkg::ST_USER;
                  cnt_reg <= 3'h0;
                  cpu_rstn_reg <= 1'b0;
                  per_rstn_reg <= 1'b0;
                  pending_reg <= rsc_pkg::CAUSE_USER;
               end
            end
            rsc_pkg::ST_USER: begin
               if (!pin_sync_reg) begin
                  cnt_reg <= 3'h0;
               end else if (slow_tick_i) begin
                  if (cnt_reg == rsc_pkg::USER_TICKS - 3'h1) begin
                     state_reg <= rsc_pkg::ST_IDLE;
                     cpu_rstn_reg <= 1'b1;
                     per_rstn_reg <= 1'b1;
                     cause_reg <= pending_reg;
                  end else begin
                     cnt_reg <= cnt_reg + 3'h1;
                  end
               end
            end
            rsc_pkg::ST_SOFT, rsc_pkg::ST_WDOG: begin
               // three slow ticks, released on a tick
               if (slow_tick_i) begin
                  if (cnt_reg == rsc_pkg::HOLD_TICKS - 3'h1) begin
                     state_reg <= rsc_pkg::ST_IDLE;
                     busy_reg <= 1'b0;
                     cpu_rstn_reg <= 1'b1;
                     per_rstn_reg <= 1'b1;
                     if (!cpu_rstn_reg) begin
                        cause_reg <= pending_reg;
                     end
                  end else begin
                     cnt_reg <= cnt_reg + 3'h1;
                  end
               end
            end
            default: begin
               state_reg <= rsc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // AXI4-Lite slave
   // ************************************************************
   // Ready pulses once per item so a held valid is taken only once
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aw_hold_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         awready_reg <= 1'b0;
      end else begin
         awready_reg <= awvalid_i && !awready_reg && !aw_hold_reg;
         if (awvalid_i && awready_reg) begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= awaddr_i;
         end else if (wr_fire) begin
            aw_hold_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         w_hold_reg <= 1'b0;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         wready_reg <= 1'b0;
      end else begin
         wready_reg <= wvalid_i && !wready_reg && !w_hold_reg;
         if (wvalid_i && wready_reg) begin
            w_hold_reg <= 1'b1;
            wdata_reg <= wdata_i;
            wstrb_reg <= wstrb_i;
         end else if (wr_fire) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   // Key failures and busy refusals still answer OKAY; only addresses other than command and mode error
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= rsc_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= (awaddr_reg == rsc_pkg::ADDR_CMD || awaddr_reg == rsc_pkg::ADDR_MODE)
            ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
      end else if (bready_i) begin
         bvalid_reg <= 1'b0;
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case (araddr_i)
         rsc_pkg::ADDR_STAT: begin
            rd_word[rsc_pkg::ST_FALL_BIT] = fall_reg;
            rd_word[rsc_pkg::ST_CAUSE_POS +: 3] = cause_reg;
            rd_word[rsc_pkg::ST_LEVEL_BIT] = pin_sync_reg;
            rd_word[rsc_pkg::ST_BUSY_BIT] = busy_reg;
         end
         rsc_pkg::ADDR_MODE: begin
            rd_word[rsc_pkg::MD_EN_BIT] = mode_reg.en;
            rd_word[rsc_pkg::MD_IRQ_BIT] = mode_reg.irq_en;
            rd_word[rsc_pkg::MD_LEN_POS +: 4] = mode_reg.len;
         end
         rsc_pkg::ADDR_CMD: begin
            rd_word = 32'h0000_0000;
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   assign sr_read = arvalid_i && arready_reg && araddr_i == rsc_pkg::ADDR_STAT;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= rsc_pkg::RESP_OKAY;
      end else begin
         arready_reg <= arvalid_i && !arready_reg && !rvalid_reg;
         if (arvalid_i && arready_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_hit ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_SLVERR;
         end else if (rready_i) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // active-low outputs straight from flops
   assign cpu_rstn_o = cpu_rstn_reg;
   assign periph_rstn_o = per_rstn_reg;
   assign pin_o = 1'b0;
   assign pin_oe_o = pin_oe_reg;
   assign irq_o = irq_reg;
   assign awready_o = awready_reg;
   assign wready_o = wready_reg;
   assign bvalid_o = bvalid_reg;
   assign bresp_o = bresp_reg;
   assign arready_o = arready_reg;
   assign rvalid_o = rvalid_reg;
   assign rdata_o = rdata_reg;
   assign rresp_o = rresp_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   a_cause_stable: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !$past(cpu_rstn_reg) && !cpu_rstn_reg |-> $stable(cause_reg))
      else $error("cause changed while processor reset held");

   a_user_cause: assert property (@(posedge clk_i) disable iff (!rstn_i)
      state_reg == rsc_pkg::ST_USER ##1 state_reg == rsc_pkg::ST_IDLE
      |-> cause_reg == rsc_pkg::CAUSE_USER)
      else $error("user reset did not report cause four");

   a_busy_blocks: assert property (@(posedge clk_i) disable iff (!rstn_i)
      busy_reg |-> state_reg == rsc_pkg::ST_SOFT && !cmd_ok)
      else $error("command taken while busy");

   a_wdog_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !watchdog_reset_allow_i && state_reg == rsc_pkg::ST_IDLE && !core_rst_i && !cmd_ok
      && !user_hit |=> state_reg == rsc_pkg::ST_IDLE)
      else $error("watchdog acted while not allowed");

   a_cmd_immediate: assert property (@(posedge clk_i) disable iff (!rstn_i)
      cmd_ok && wdata_reg[rsc_pkg::CMD_CPU_BIT] |=> !cpu_rstn_reg && busy_reg)
      else $error("processor command not asserted next cycle");

   a_user_needs_en: assert property (@(posedge clk_i) disable iff (!rstn_i)
      state_reg == rsc_pkg::ST_IDLE ##1 state_reg == rsc_pkg::ST_USER
      |-> $past(mode_reg.en))
      else $error("user reset entered with enable off");

   a_pin_length: assert property (@(posedge clk_i) disable iff (!rstn_i)
      pin_start && mode_reg.len == 4'h0 |=> pin_cnt_reg == 17'h2)
      else $error("pin pulse length wrong");

   a_fall_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
      pin_prev_reg && !pin_sync_reg |=> fall_reg)
      else $error("pin fall not recorded");

   a_irq_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
      irq_reg |-> !mode_reg.en || !$past(mode_reg.en))
      else $error("interrupt while pin reset enabled");

   a_core_wins: assert property (@(posedge clk_i) disable iff (!rstn_i)
      core_rst_i |=> state_reg == rsc_pkg::ST_GENERAL && !cpu_rstn_reg)
      else $error("core reset did not take priority");

endmodule : rsc_reset_ctrl

`default_nettype wire

// ---- logic/rsc_pkg.sv ----
// Constants and types shared by the system reset controller.
// Assumes a single 100 MHz clock and a slow clock tick from the same domain.
package rsc_pkg;

   // ************************************************************
   // Register map and fields
   // ************************************************************
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_MODE = 8'h08;
   localparam int KEY_POS = 24;
   localparam logic [7:0] KEY_VAL = 8'ha5;
   localparam int CMD_CPU_BIT = 0;
   localparam int CMD_PER_BIT = 2;
   localparam int CMD_PIN_BIT = 3;
   localparam int ST_FALL_BIT = 0;
   localparam int ST_CAUSE_POS = 8;
   localparam int ST_LEVEL_BIT = 16;
   localparam int ST_BUSY_BIT = 17;
   localparam int MD_EN_BIT = 0;
   localparam int MD_IRQ_BIT = 4;
   localparam int MD_LEN_POS = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************************
   // Reset causes and timing
   // ************************************************************
   localparam logic [2:0] CAUSE_GENERAL = 3'h0;
   localparam logic [2:0] CAUSE_BACKUP = 3'h1;
   localparam logic [2:0] CAUSE_WATCHDOG = 3'h2;
   localparam logic [2:0] CAUSE_SOFTWARE = 3'h3;
   localparam logic [2:0] CAUSE_USER = 3'h4;
   localparam logic [2:0] HOLD_TICKS = 3'h3;
   localparam logic [2:0] USER_TICKS = 3'h5;

   typedef struct packed {
      logic [3:0] len;
      logic irq_en;
      logic en;
   } rsc_mode_type;

   localparam rsc_mode_type MODE_RESET = '{len: 4'h0, irq_en: 1'b0, en: 1'b1};

   typedef enum logic [2:0] {
      ST_GENERAL,
      ST_IDLE,
      ST_USER,
      ST_SOFT,
      ST_WDOG
   } rsc_state_type;

endpackage : rsc_pkg

// ---- verif/rsc_pin_partner.sv ----
// Other devices on the open-drain reset line, with its pull-up.
// Assumes the design's enable means drive low; the bench asks for holds.
`timescale 1ns/10ps
`default_nettype none
module rsc_pin_partner (
   input wire logic drive_low_i,
   input wire logic hold_low_i,
   output logic level_o
);
   // external holder wins
   // A released line goes to the pull-up level, not to its last value
   assign level_o = !(drive_low_i || hold_low_i);
endmodule : rsc_pin_partner
`default_nettype wire

// ---- verif/test_system_reset_controller.sv ----
// Self-checking bench for the reset controller over AXI4-Lite.
// Assumes a slow tick every fourth clock and the pin partner model.
`timescale 1ns/10ps
`default_nettype none
module test_system_reset_controller;
   typedef struct packed {
      logic [7:0] wa;
      logic [31:0] wd;
      logic [7:0] ra;
      logic [31:0] ed;
      logic [1:0] er;
   } rsc_row_type;
   logic clk_i, rstn_i, slow_tick_i, core_rst_i, from_backup_i, wdt_fault_i;
   logic watchdog_cpu_only_i, watchdog_reset_allow_i, pin_line, hold_low;
   logic pin_o, pin_oe_o, cpu_rstn_o, periph_rstn_o, irq_o;
   logic [7:0] awaddr_i, araddr_i;
   logic awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i;
   logic arvalid_i, arready_o, rvalid_o, rready_i;
   logic [31:0] wdata_i, rdata_o, s;
   logic [3:0] wstrb_i;
   logic [1:0] bresp_o, rresp_o, r, b;
   logic [1:0] tcnt = 2'h0;
   int error_cnt, num_checks, n, t;
   rsc_row_type rows [5];

   rsc_reset_ctrl rsc_reset_ctrl_inst (
      .clk_i(clk_i), .rstn_i(rstn_i), .slow_tick_i(slow_tick_i), .core_rst_i(core_rst_i),
      .from_backup_i(from_backup_i), .wdt_fault_i(wdt_fault_i),
      .watchdog_cpu_only_i(watchdog_cpu_only_i),
      .watchdog_reset_allow_i(watchdog_reset_allow_i), .pin_i(pin_line), .pin_o(pin_o),
      .pin_oe_o(pin_oe_o), .cpu_rstn_o(cpu_rstn_o), .periph_rstn_o(periph_rstn_o),
      .irq_o(irq_o), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
      .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
      .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i),
      .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
      .rvalid_o(rvalid_o), .rready_i(rready_i));
   rsc_pin_partner rsc_pin_partner_inst (
      .drive_low_i(pin_oe_o), .hold_low_i(hold_low), .level_o(pin_line));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      tcnt <= tcnt + 2'h1;
      slow_tick_i <= (tcnt == 2'h3);
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s", $time, m);
      end
   endtask : chk
   function automatic logic sig(input int w);
      case (w)
         0: return cpu_rstn_o;
         1: return periph_rstn_o;
         2: return irq_o;
         default: return pin_oe_o;
      endcase
   endfunction : sig
   // Bounded wait, then a check that the level arrived
   task wait_sig(input int w, input logic v);
      n = 0;
      while (sig(w) !== v && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(sig(w)), 32'(v), "signal wait");
   endtask : wait_sig
   task ticks_while(input int w, input logic v);
      t = 0;
      n = 0;
      if (slow_tick_i === 1'b1 && sig(w) === v) t++;
      while (sig(w) === v && n < 2000) begin
         @(posedge clk_i);
         n++;
         if (slow_tick_i === 1'b1 && sig(w) === v) t++;
      end
   endtask : ticks_while
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      awaddr_i <= a;
      wdata_i <= d;
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      bready_i <= 1'b1;
      fork
         begin
            do @(posedge clk_i); while (awready_o !== 1'b1);
            awvalid_i <= 1'b0;
         end
         begin
            do @(posedge clk_i); while (wready_o !== 1'b1);
            wvalid_i <= 1'b0;
         end
      join
      do @(posedge clk_i); while (bvalid_o !== 1'b1);
      b = bresp_o;
      bready_i <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge clk_i);
      araddr_i <= a;
      arvalid_i <= 1'b1;
      rready_i <= 1'b1;
      do @(posedge clk_i); while (arready_o !== 1'b1);
      arvalid_i <= 1'b0;
      do @(posedge clk_i); while (rvalid_o !== 1'b1);
      s = rdata_o;
      r = rresp_o;
      rready_i <= 1'b0;
   endtask : rd
   task pulse(input logic core, input logic bkp);
      core_rst_i <= core;
      from_backup_i <= bkp;
      wdt_fault_i <= !core;
      repeat (3) @(posedge clk_i);
      {core_rst_i, from_backup_i, wdt_fault_i} <= 3'h0;
      repeat (20) @(posedge clk_i);
   endtask : pulse
   task end_of_test();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #300us;
      error_cnt++;
      end_of_test();
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {rstn_i, core_rst_i, from_backup_i, wdt_fault_i, watchdog_cpu_only_i, hold_low} = '0;
      {watchdog_reset_allow_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
      {awaddr_i, araddr_i, wdata_i} = '0;
      wstrb_i = 4'hf;
      rows = '{'{8'h08, 32'ha5000310, 8'h08, 32'h310, rsc_pkg::RESP_OKAY},
               '{8'h08, 32'h12000501, 8'h08, 32'h310, rsc_pkg::RESP_OKAY},
               '{8'h08, 32'ha5000201, 8'h08, 32'h201, rsc_pkg::RESP_OKAY},
               '{8'h0c, 32'ha5000001, 8'h0c, 32'h0, rsc_pkg::RESP_SLVERR},
               '{8'h00, 32'h5a000001, 8'h04, 32'h10000, rsc_pkg::RESP_OKAY}};
      repeat (8) @(posedge clk_i);
      chk(32'({cpu_rstn_o, periph_rstn_o, pin_oe_o, irq_o, bvalid_o, rvalid_o}), 32'h0, "in reset");
      rstn_i <= 1'b1;
      wait_sig(3, 1'b1);
      wait_sig(0, 1'b1);
      repeat (40) @(posedge clk_i);
      rd(8'h04);
      chk(s & 32'h00030700, 32'h00010000, "power-up status");
      rd(8'h08);
      chk(s, 32'h1, "mode reset value");
      for (int i = 0; i < 5; i++) begin
         wr(rows[i].wa, rows[i].wd);
         rd(rows[i].ra);
         chk(s, rows[i].ed, "row data");
         chk(32'(r), 32'(rows[i].er), "row resp");
         chk(32'(b), 32'(rows[i].er), "row bresp");
      end
      wr(8'h00, 32'ha5000005);
      rd(8'h04);
      chk(32'(s[17]), 32'h1, "busy flag");
      chk(32'({cpu_rstn_o, periph_rstn_o}), 32'h0, "sw resets");
      wr(8'h00, 32'ha5000008);
      chk(32'(pin_oe_o), 32'h0, "cmd while busy");
      wait_sig(0, 1'b1);
      rd(8'h04);
      chk(s & 32'h00020700, 32'h300, "sw cause");
      wr(8'h00, 32'ha5000008);
      wait_sig(3, 1'b1);
      ticks_while(3, 1'b1);
      chk(32'(t >= 8 && t <= 9), 32'h1, "pin pulse length");
      repeat (40) @(posedge clk_i);
      chk(32'(cpu_rstn_o), 32'h1, "own pulse");
      rd(8'h04);
      chk(32'(s[10:8]), 32'h3, "pin cmd cause");
      hold_low <= 1'b1;
      wait_sig(0, 1'b0);
      chk(32'(periph_rstn_o), 32'h0, "user periph");
      repeat (120) @(posedge clk_i);
      chk(32'(cpu_rstn_o), 32'h0, "pin held");
      hold_low <= 1'b0;
      @(posedge clk_i);
      ticks_while(0, 1'b0);
      chk(32'(t >= 5 && t <= 6), 32'h1, "user release");
      rd(8'h04);
      chk(32'({s[10:8], s[0]}), 32'h9, "user cause, fall");
      rd(8'h04);
      chk(32'(s[0]), 32'h0, "fall cleared");
      wr(8'h08, 32'ha5000010);
      hold_low <= 1'b1;
      wait_sig(2, 1'b1);
      repeat (20) @(posedge clk_i);
      chk(32'(cpu_rstn_o), 32'h1, "user disabled");
      hold_low <= 1'b0;
      rd(8'h04);
      repeat (2) @(posedge clk_i);
      chk(32'(irq_o), 32'h0, "irq cleared");
      pulse(1'b0, 1'b0);
      chk(32'(cpu_rstn_o), 32'h1, "wdog blocked");
      watchdog_reset_allow_i <= 1'b1;
      watchdog_cpu_only_i <= 1'b1;
      wdt_fault_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      wdt_fault_i <= 1'b0;
      chk(32'({cpu_rstn_o, periph_rstn_o, pin_oe_o}), 32'h2, "wdog cpu only");
      wait_sig(0, 1'b1);
      rd(8'h04);
      chk(32'(s[10:8]), 32'h2, "wdog cause");
      watchdog_cpu_only_i <= 1'b0;
      wdt_fault_i <= 1'b1;
      wait_sig(3, 1'b1);
      chk(32'({pin_o, periph_rstn_o}), 32'h0, "wdog periph");
      wdt_fault_i <= 1'b0;
      wait_sig(0, 1'b1);
      pulse(1'b1, 1'b1);
      wait_sig(0, 1'b1);
      rd(8'h04);
      chk(32'(s[10:8]), 32'h1, "backup cause");
      rd(8'h08);
      chk(s, 32'h10, "mode kept");
      pulse(1'b1, 1'b0);
      wait_sig(0, 1'b1);
      rd(8'h04);
      chk(32'(s[10:8]), 32'h0, "general cause");
      rd(8'h08);
      chk(s, 32'h1, "mode cleared");
      end_of_test();
   end
endmodule : test_system_reset_controller
`default_nettype wire
